// ===== design/pin_irq_ctrl.sv
// Pin interrupt channels and debug pin configuration, AXI4-Lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
module pin_irq_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic irq_a_pin,
  input wire logic irq_b_pin,
  input wire logic [23:0] port_pins,
  // Debug side inputs
  input wire logic debug_active,
  input wire logic debug_forced,
  input wire logic serial_wire_en,
  input wire logic boot_mode_n,
  // Interrupt outputs
  output logic ext_interrupt_a,
  output logic ext_interrupt_b,
  output logic ext_interrupt_c,
  output logic ext_interrupt_d,
  output logic irq,
  // Pin override outputs
  output logic debug_permit,
  output logic regulator_enable_override
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  function automatic logic pick_pin(input logic [23:0] pins,
                                    input logic [4:0] sel);
    logic res;
    res = 1'b0;
    if (sel <= pin_irq_pkg::SEL_LAST_PIN) begin
      res = pins[sel];
    end
    return res;
  endfunction : pick_pin

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  pin_irq_pkg::ch_cfg_s cfg_r [pin_irq_pkg::NUM_CH];
  logic [4:0] sel_c_r;
  logic [4:0] sel_d_r;
  logic [5:0] dbg_cfg_r;
  logic [3:0] pending_r;
  logic [3:0] pending_nxt;
  logic [3:0] mask_r;
  pin_irq_pkg::dbg_stat_s dbg_stat_r;
  logic boot_taken_r;

  // ----------------------------------------------------------------
  // AXI4-Lite state
  // ----------------------------------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic rd_hit;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

  // ----------------------------------------------------------------
  // Write channel capture and response
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= pin_irq_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? pin_irq_pkg::RESP_OKAY : pin_irq_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register read view, shared by read path and write merge
  // ----------------------------------------------------------------
  function automatic logic [31:0] reg_view(input logic [31:0] addr,
                                           output logic hit);
    logic [31:0] v;
    v = 32'h0000_0000;
    hit = 1'b1;
    case (addr)
      pin_irq_pkg::PENDING_ADDR: v[3:0] = pending_r;
      pin_irq_pkg::MASK_ADDR: v[3:0] = mask_r;
      pin_irq_pkg::CFG_A_ADDR: v[8:5] = cfg_r[0];
      pin_irq_pkg::CFG_B_ADDR: v[8:5] = cfg_r[1];
      pin_irq_pkg::CFG_C_ADDR: v[8:5] = cfg_r[2];
      pin_irq_pkg::CFG_D_ADDR: v[8:5] = cfg_r[3];
      pin_irq_pkg::DBG_CFG_ADDR: v[5:3] = dbg_cfg_r[5:3];
      pin_irq_pkg::DBG_STAT_ADDR: begin
        v[pin_irq_pkg::STAT_BOOT_BIT] = dbg_stat_r.boot_asserted;
        v[pin_irq_pkg::STAT_FORCE_BIT] = dbg_stat_r.forced;
        v[pin_irq_pkg::STAT_SWEN_BIT] = dbg_stat_r.swen;
      end
      pin_irq_pkg::SEL_C_ADDR: v[4:0] = sel_c_r;
      pin_irq_pkg::SEL_D_ADDR: v[4:0] = sel_d_r;
      default: hit = 1'b0;
    endcase
    return v;
  endfunction : reg_view

  always_comb begin
    wr_old = reg_view(aw_addr_r, wr_hit);
    wr_val = merge_strb(wr_old, w_data_r, w_strb_r);
    rd_val = reg_view(s_axi_araddr, rd_hit);
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= pin_irq_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? pin_irq_pkg::RESP_OKAY : pin_irq_pkg::RESP_SLVERR;
      rdata_r <= rd_val;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < pin_irq_pkg::NUM_CH; i++) begin
        cfg_r[i] <= '0;
      end
    end else if (wr_fire) begin
      // Modes 6 and 7 are stored but never trigger
      case (aw_addr_r)
        pin_irq_pkg::CFG_A_ADDR: cfg_r[0] <= wr_val[8:5];
        pin_irq_pkg::CFG_B_ADDR: cfg_r[1] <= wr_val[8:5];
        pin_irq_pkg::CFG_C_ADDR: cfg_r[2] <= wr_val[8:5];
        pin_irq_pkg::CFG_D_ADDR: cfg_r[3] <= wr_val[8:5];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_c_r <= pin_irq_pkg::SEL_C_RST;
      sel_d_r <= pin_irq_pkg::SEL_D_RST;
    end else if (wr_fire) begin
      case (aw_addr_r)
        pin_irq_pkg::SEL_C_ADDR: sel_c_r <= wr_val[pin_irq_pkg::SEL_MSB:0];
        pin_irq_pkg::SEL_D_ADDR: sel_d_r <= wr_val[pin_irq_pkg::SEL_MSB:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_cfg_r <= pin_irq_pkg::DBG_CFG_RST;
      mask_r <= 4'h0;
    end else if (wr_fire) begin
      if (aw_addr_r == pin_irq_pkg::DBG_CFG_ADDR) begin
        dbg_cfg_r <= {wr_val[5:3], 3'b000};
      end
      if (aw_addr_r == pin_irq_pkg::MASK_ADDR) begin
        mask_r <= wr_val[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Debug status, boot strap caught once after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_taken_r <= 1'b0;
      dbg_stat_r <= '0;
    end else begin
      boot_taken_r <= 1'b1;
      if (!boot_taken_r) begin
        dbg_stat_r.boot_asserted <= !boot_mode_n;
      end
      dbg_stat_r.forced <= debug_forced;
      dbg_stat_r.swen <= serial_wire_en;
    end
  end

  assign debug_permit =
    !dbg_cfg_r[pin_irq_pkg::DBG_DIS_BIT] || debug_active;
  assign regulator_enable_override =
    dbg_cfg_r[pin_irq_pkg::REG_EN_BIT];

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic [3:0] src_pin;
  logic [3:0] cond;
  logic [3:0] fire;

  assign src_pin[0] = irq_a_pin;
  assign src_pin[1] = irq_b_pin;
  assign src_pin[2] = pick_pin(port_pins, sel_c_r);
  assign src_pin[3] = pick_pin(port_pins, sel_d_r);

  for (genvar g = 0; g < pin_irq_pkg::NUM_CH; g++) begin : g_ch
    pin_conditioner #(
      .LEN(pin_irq_pkg::FILTER_LEN)
    ) u_cond (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(src_pin[g]),
      .filt_en(cfg_r[g].filt),
      .cond(cond[g])
    );
    trigger_detect u_trig (
      .aclk(aclk),
      .aresetn(aresetn),
      .lvl(cond[g]),
      .mode(cfg_r[g].mode),
      .fire(fire[g])
    );
  end

  // ----------------------------------------------------------------
  // Pending flags: a trigger in the clearing cycle wins
  // ----------------------------------------------------------------
  always_comb begin
    pending_nxt = pending_r;
    if (wr_fire && aw_addr_r == pin_irq_pkg::PENDING_ADDR) begin
      // Only written bytes clear; a merged old value would clear set flags
      pending_nxt = pending_r & ~(w_data_r[3:0] & {4{w_strb_r[0]}});
    end
    pending_nxt = pending_nxt | fire;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_r <= 4'h0;
    end else begin
      pending_r <= pending_nxt;
    end
  end

  assign ext_interrupt_a = pending_r[0];
  assign ext_interrupt_b = pending_r[1];
  assign ext_interrupt_c = pending_r[2];
  assign ext_interrupt_d = pending_r[3];
  assign irq = |(pending_r & mask_r);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pending_set: assert property (@(posedge aclk) disable iff (!aresetn)
    fire[2] |=> pending_r[2])
    else $error("pending flag not set by trigger");
  a_w1c_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr_r == pin_irq_pkg::PENDING_ADDR && w_strb_r[0]
     && w_data_r[0] && !fire[0]) |=> !pending_r[0])
    else $error("pending flag not cleared by write one");
  a_sel_reset: assert property (@(posedge aclk)
    !aresetn |=> (sel_c_r == 5'h0f && sel_d_r == 5'h10))
    else $error("selector reset value wrong");
  a_dbg_reset: assert property (@(posedge aclk)
    !aresetn |=> (dbg_cfg_r == 6'h10 && regulator_enable_override))
    else $error("debug config reset value wrong");
  a_mux_pick: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_c_r <= 5'h17) |-> (src_pin[2] == port_pins[sel_c_r]))
    else $error("channel c source pin wrong");
  a_level_refire: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg_r[1].mode == pin_irq_pkg::MODE_HIGH && cond[1]
     && $stable(cfg_r[1])) |=> pending_r[1])
    else $error("level mode flag not held");
  a_chan_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    fire[1] |=> ext_interrupt_b)
    else $error("channel request not raised");
  a_debug_block: assert property (@(posedge aclk) disable iff (!aresetn)
    (dbg_cfg_r[5] && !debug_active) |-> !debug_permit)
    else $error("debug takeover not blocked");
  a_off_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg_r[0].mode == pin_irq_pkg::MODE_OFF) |-> !fire[0])
    else $error("disabled channel triggered");

endmodule : pin_irq_ctrl

// ===== design/pin_irq_pkg.sv
// Shared constants and types for the pin interrupt and debug config block
package pin_irq_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] PENDING_ADDR = 32'h4000a814;
  localparam logic [31:0] MASK_ADDR = 32'h4000a818;
  localparam logic [31:0] CFG_A_ADDR = 32'h4000a860;
  localparam logic [31:0] CFG_B_ADDR = 32'h4000a864;
  localparam logic [31:0] CFG_C_ADDR = 32'h4000a868;
  localparam logic [31:0] CFG_D_ADDR = 32'h4000a86c;
  localparam logic [31:0] DBG_CFG_ADDR = 32'h4000bc00;
  localparam logic [31:0] DBG_STAT_ADDR = 32'h4000bc04;
  localparam logic [31:0] SEL_C_ADDR = 32'h4000bc14;
  localparam logic [31:0] SEL_D_ADDR = 32'h4000bc18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FILT_BIT = 8;
  localparam int MODE_LSB = 5;
  localparam int MODE_MSB = 7;
  localparam int SEL_MSB = 4;
  localparam int DBG_DIS_BIT = 5;
  localparam int REG_EN_BIT = 4;
  localparam int DBG_RSVD_BIT = 3;
  localparam int STAT_BOOT_BIT = 3;
  localparam int STAT_FORCE_BIT = 1;
  localparam int STAT_SWEN_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values, sizes and timing
  // ----------------------------------------------------------------
  localparam logic [4:0] SEL_C_RST = 5'h0f;
  localparam logic [4:0] SEL_D_RST = 5'h10;
  localparam logic [5:0] DBG_CFG_RST = 6'h10;
  localparam logic [4:0] SEL_LAST_PIN = 5'h17;
  localparam int NUM_CH = 4;
  localparam int PIN_COUNT = 24;
  localparam int FILTER_LEN = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_RISE = 3'b001,
    MODE_FALL = 3'b010,
    MODE_BOTH = 3'b011,
    MODE_HIGH = 3'b100,
    MODE_LOW = 3'b101,
    MODE_RSVD6 = 3'b110,
    MODE_RSVD7 = 3'b111
  } trig_mode_e;

  typedef struct packed {
    logic filt;
    trig_mode_e mode;
  } ch_cfg_s;

  typedef struct packed {
    logic boot_asserted;
    logic forced;
    logic swen;
  } dbg_stat_s;

endpackage : pin_irq_pkg

// ===== design/pin_conditioner.sv
// Pin synchroniser with optional digital filter
module pin_conditioner #(
  parameter int LEN = pin_irq_pkg::FILTER_LEN
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and control
  input wire logic pin,
  input wire logic filt_en,
  output logic cond
);
  logic sync1_r;
  logic sync2_r;
  logic filt_r;
  logic [7:0] cnt_r;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // Filter: a new level must hold LEN samples
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (!filt_en || sync2_r == filt_r) begin
      // Tracking while off avoids a false edge when enabled
      filt_r <= sync2_r;
      cnt_r <= 8'h00;
    end else if (cnt_r == 8'(LEN - 1)) begin
      filt_r <= sync2_r;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign cond = filt_en ? filt_r : sync2_r;

endmodule : pin_conditioner

// ===== design/trigger_detect.sv
// Edge and level trigger detection for one channel
module trigger_detect (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Conditioned level and mode
  input wire logic lvl,
  input wire pin_irq_pkg::trig_mode_e mode,
  output logic fire
);
  logic prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= lvl;
    end
  end

  always_comb begin
    case (mode)
      pin_irq_pkg::MODE_RISE: fire = lvl & ~prev_r;
      pin_irq_pkg::MODE_FALL: fire = ~lvl & prev_r;
      pin_irq_pkg::MODE_BOTH: fire = lvl ^ prev_r;
      pin_irq_pkg::MODE_HIGH: fire = lvl;
      pin_irq_pkg::MODE_LOW: fire = ~lvl;
      default: fire = 1'b0;
    endcase
  end

  a_rise_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == pin_irq_pkg::MODE_RISE && lvl && !$past(lvl)) |-> fire)
    else $error("rising edge missed");
  a_level_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == pin_irq_pkg::MODE_LOW) |-> (fire == !lvl))
    else $error("low level trigger wrong");

endmodule : trigger_detect

// ===== dv/pin_model.sv
// Behavioural driver for the external port and channel pins
module pin_model (
  // Clock
  input wire logic aclk,
  // Pins
  output logic irq_a_pin,
  output logic irq_b_pin,
  output logic [23:0] port_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    irq_a_pin = 1'b0;
    irq_b_pin = 1'b0;
    port_pins = 24'h000000;
  end

  // Pins move just after an edge, so the sync stage sees clean samples
  // Index 24 and 25 stand for the fixed pins of channels A and B
  task automatic drive(input int idx, input logic v);
    @(posedge aclk);
    if (idx == 24) irq_a_pin <= v;
    else if (idx == 25) irq_b_pin <= v;
    else port_pins[idx] <= v;
  endtask : drive
endmodule : pin_model

// ===== dv/pin_irq_and_debug_config_tb_top.sv
// Self-checking testbench for the pin interrupt and debug config block
module pin_irq_and_debug_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_PEND = pin_irq_pkg::PENDING_ADDR;
  localparam logic [31:0] A_CFGA = pin_irq_pkg::CFG_A_ADDR;
  localparam logic [31:0] A_DCFG = pin_irq_pkg::DBG_CFG_ADDR;
  localparam logic [31:0] A_MASK = pin_irq_pkg::MASK_ADDR;
  localparam logic [31:0] A_NONE = 32'h4000a800;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic dbg_act = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_a, pin_b;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] pins;
  logic int_a, int_b, int_c, int_d, irq, permit, reg_ovr;
  int miscompares = 0;
  int checks_done = 0;

  always #10 aclk = ~aclk;

  pin_model pins_u (.aclk(aclk), .irq_a_pin(pin_a), .irq_b_pin(pin_b),
    .port_pins(pins));

  pin_irq_ctrl dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_a_pin(pin_a), .irq_b_pin(pin_b),
    .port_pins(pins), .debug_active(dbg_act), .debug_forced(1'b1),
    .serial_wire_en(1'b1), .boot_mode_n(1'b0),
    .ext_interrupt_a(int_a), .ext_interrupt_b(int_b),
    .ext_interrupt_c(int_c), .ext_interrupt_d(int_d), .irq(irq),
    .debug_permit(permit), .regulator_enable_override(reg_ovr));

  // ----------------------------------------------------------------
  // Checks and bus cycles
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] e);
    checks_done++;
    if (got !== e) begin
      miscompares++;
      $display("unexpected at %0t: word %h, want %h", $time, got, e);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic e);
    checks_done++;
    if (got !== e) begin
      miscompares++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, e);
    end
  endtask : cmp_bit

  // Outputs are read 1 ns after the edge so that edge's updates land
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : tick

  // Handshakes are judged at the rising edge, before its updates land
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
      input logic [1:0] er = pin_irq_pkg::RESP_OKAY);
    logic aw_t, w_t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_t = 1'b0;
    w_t = 1'b0;
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        aw_t = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        w_t = 1'b1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    cmp_word({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask : wr

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e,
      input logic [1:0] er = pin_irq_pkg::RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    cmp_word(rdata, e);
    cmp_word({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask : chk_rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk_rd(A_PEND, 32'h0);
    for (int i = 0; i < 4; i++) chk_rd(A_CFGA + 4 * i, 32'h0);
    chk_rd(pin_irq_pkg::SEL_C_ADDR, 32'hf);
    chk_rd(pin_irq_pkg::SEL_D_ADDR, 32'h10);
    chk_rd(A_DCFG, 32'h10);
    chk_rd(A_MASK, 32'h0);
    chk_rd(pin_irq_pkg::DBG_STAT_ADDR, 32'hb);
    cmp_bit(reg_ovr, 1'b1);
    cmp_bit(permit, 1'b1);
    wr(A_NONE, 32'hffffffff, pin_irq_pkg::RESP_SLVERR);
    chk_rd(A_NONE, 32'h0, pin_irq_pkg::RESP_SLVERR);
    chk_rd(A_PEND, 32'h0);
  endtask : t_reset

  task automatic t_edges();
    // Only defined modes are written; 6 and 7 stay unused
    for (int m = 0; m < 4; m++) begin
      wr(A_CFGA, m << 5);
      pins_u.drive(24, 1'b1);
      tick(6);
      cmp_bit(int_a, m == 1 || m == 3);
      wr(A_PEND, 32'h1);
      tick(1);
      cmp_bit(int_a, 1'b0);
      pins_u.drive(24, 1'b0);
      tick(6);
      wr(A_PEND, 32'he);
      chk_rd(A_PEND, {31'h0, m >= 2});
      wr(A_PEND, 32'h1);
    end
  endtask : t_edges

  task automatic t_levels();
    wr(A_CFGA + 4, 32'h80);
    tick(6);
    cmp_bit(int_b, 1'b0);
    pins_u.drive(25, 1'b1);
    tick(6);
    cmp_bit(int_b, 1'b1);
    wr(A_PEND, 32'h2);
    tick(3);
    cmp_bit(int_b, 1'b1);
    wr(A_CFGA + 4, 32'ha0);
    wr(A_PEND, 32'h2);
    tick(3);
    cmp_bit(int_b, 1'b0);
    pins_u.drive(25, 1'b0);
    tick(6);
    cmp_bit(int_b, 1'b1);
    wr(A_CFGA + 4, 32'h0);
    wr(A_PEND, 32'h2);
    tick(3);
    cmp_bit(int_b, 1'b0);
  endtask : t_levels

  task automatic t_select();
    logic [4:0] codes [4] = '{5'h00, 5'h08, 5'h10, 5'h17};
    logic [31:0] sa;
    for (int ch = 0; ch < 2; ch++) begin
      sa = ch ? pin_irq_pkg::SEL_D_ADDR : pin_irq_pkg::SEL_C_ADDR;
      wr(A_CFGA + 8 + 4 * ch, 32'h20);
      // Only legal pin codes are written; reserved ones select nothing
      for (int k = 0; k < 4; k++) begin
        wr(sa, {27'h0, codes[k]});
        chk_rd(sa, {27'h0, codes[k]});
        pins_u.drive(codes[k] ^ 5'h01, 1'b1);
        tick(6);
        cmp_bit(ch ? int_d : int_c, 1'b0);
        pins_u.drive(codes[k], 1'b1);
        tick(6);
        cmp_bit(ch ? int_d : int_c, 1'b1);
        pins_u.drive(codes[k], 1'b0);
        pins_u.drive(codes[k] ^ 5'h01, 1'b0);
        wr(A_PEND, 32'hc);
      end
      wr(A_CFGA + 8 + 4 * ch, 32'h0);
    end
  endtask : t_select

  task automatic t_filter();
    wr(pin_irq_pkg::SEL_D_ADDR, 32'h10);
    wr(A_CFGA + 12, 32'h20);
    pins_u.drive(16, 1'b1);
    pins_u.drive(16, 1'b0);
    tick(6);
    cmp_bit(int_d, 1'b1);
    wr(A_PEND, 32'h8);
    wr(A_CFGA + 12, 32'h120);
    pins_u.drive(16, 1'b1);
    pins_u.drive(16, 1'b0);
    tick(12);
    cmp_bit(int_d, 1'b0);
    pins_u.drive(16, 1'b1);
    tick(3);
    cmp_bit(int_d, 1'b0);
    tick(6);
    cmp_bit(int_d, 1'b1);
    pins_u.drive(16, 1'b0);
    wr(A_CFGA + 12, 32'h0);
    wr(A_PEND, 32'h8);
  endtask : t_filter

  task automatic t_debug();
    // Reserved bit 3 reads 0 after reset and takes write data bit 3, so these writes keep it 0
    wr(A_DCFG, 32'h10);
    wr(A_DCFG, 32'h30);
    tick(1);
    cmp_bit(permit, 1'b0);
    cmp_bit(reg_ovr, 1'b1);
    @(posedge aclk);
    dbg_act <= 1'b1;
    #1;
    cmp_bit(permit, 1'b1);
    chk_rd(A_DCFG, 32'h30);
    wr(A_DCFG, 32'h00);
    @(posedge aclk);
    dbg_act <= 1'b0;
    #1;
    cmp_bit(reg_ovr, 1'b0);
    cmp_bit(permit, 1'b1);
    chk_rd(A_DCFG, 32'h00);
  endtask : t_debug

  task automatic t_mask();
    wr(A_CFGA, 32'h80);
    pins_u.drive(24, 1'b1);
    tick(6);
    cmp_bit(irq, 1'b0);
    wr(A_MASK, 32'h1);
    tick(1);
    cmp_bit(irq, 1'b1);
    wr(A_MASK, 32'h2);
    tick(1);
    cmp_bit(irq, 1'b0);
    chk_rd(A_MASK, 32'h2);
    wr(A_CFGA, 32'h0);
    wr(A_PEND, 32'h1);
    wr(A_MASK, 32'h1);
    tick(1);
    cmp_bit(irq, 1'b0);
    cmp_bit(int_a, 1'b0);
    pins_u.drive(24, 1'b0);
  endtask : t_mask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    t_reset();
    t_edges();
    t_levels();
    t_select();
    t_filter();
    t_debug();
    t_mask();
    final_report();
  end

  // Whole sequence needs well under a thousand cycles; 20000 cycles is ample
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
endmodule : pin_irq_and_debug_config_tb_top
